// file: pkg/ccc_consts.svh
`ifndef CCC_CONSTS_SVH
`define CCC_CONSTS_SVH

// ----------------------------------------------------------------------
// sizes
// ----------------------------------------------------------------------
`define CCC_NUM_CH          8
`define CCC_CH_W            3
`define CCC_OP_W            4
`define CCC_ADDR_W          10
`define CCC_DATA_W          32
`define CCC_PTR_W           8
`define CCC_EV_W            3

// ----------------------------------------------------------------------
// shared memory layout, in words
// ----------------------------------------------------------------------
`define CCC_MEM_WORDS       1024
`define CCC_PRAM_BASE       10'h000
`define CCC_PRAM_SHIFT      6
`define CCC_VFIFO_BASE      10'h200
`define CCC_VFIFO_SHIFT     5

// parameter block word 0 and word 1 fields
`define CCC_PW0_BD_EXT      0
`define CCC_PW0_TXPTR_LSB   8
`define CCC_PW1_RXPTR_LSB   0

// ----------------------------------------------------------------------
// command codes
// ----------------------------------------------------------------------
`define CCC_OP_INIT         4'h0
`define CCC_OP_GSTOP_TX     4'h1
`define CCC_OP_STOP_TX      4'h2
`define CCC_OP_RESTART_TX   4'h3
`define CCC_OP_STOP_RX      4'h4
`define CCC_OP_RESTART_RX   4'h5
`define CCC_OP_HUNT_RX      4'h6

// channel protocols
`define CCC_PROTO_UART      2'h0
`define CCC_PROTO_HDLC      2'h1
`define CCC_PROTO_TRANS     2'h2

// ----------------------------------------------------------------------
// per-channel register space
// ----------------------------------------------------------------------
`define CCC_REG_MODE        2'h0
`define CCC_REG_EVENT       2'h1
`define CCC_REG_STATUS      2'h2

`define CCC_EV_INIT_DONE    0
`define CCC_EV_TX_STOPPED   1
`define CCC_EV_HUNT         2

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define CCC_RESET_CYCLES    3'h4

`endif

// file: pkg/ccc_pkg.sv
`include "ccc_consts.svh"

package ccc_pkg;

  typedef enum logic [2:0]
  {
    ST_IDLE,
    ST_FETCH0,
    ST_FETCH1,
    ST_FETCH2,
    ST_GSTOP,
    ST_STOP,
    ST_RESET
  } ccc_state_e;

  typedef logic [`CCC_NUM_CH-1:0]                  ccc_chvec_t;
  typedef logic [`CCC_NUM_CH-1:0][`CCC_PTR_W-1:0]  ccc_ptrs_t;

  typedef struct packed
  {
    ccc_state_e                           st;
    logic                                 pending;
    logic                                 done;
    logic                                 err;
    logic [`CCC_OP_W-1:0]                 op;
    logic [`CCC_CH_W-1:0]                 ch;
    logic [2:0]                           rst_cnt;
    logic                                 eng_rst;
    ccc_chvec_t                           tx_en;
    ccc_chvec_t                           rx_en;
    ccc_chvec_t                           ready;
    ccc_chvec_t                           bd_ext;
    ccc_chvec_t                           vfifo_en;
    ccc_ptrs_t                            tx_ptr;
    ccc_ptrs_t                            rx_ptr;
    logic [`CCC_NUM_CH-1:0][1:0]          proto;
    logic [`CCC_NUM_CH-1:0][`CCC_EV_W-1:0] events;
    logic                                 h_p1;
    logic                                 h_space;
    logic                                 ack;
    logic [`CCC_DATA_W-1:0]               hold;
    logic [`CCC_DATA_W-1:0]               rdata;
  } ccc_state_s;

endpackage : ccc_pkg

// file: hw/ccc_shared_mem.sv
`timescale 1ns/1ps
`include "ccc_consts.svh"

module ccc_shared_mem
(
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   rst_b,
  // single access port
  input  wire logic                   en,
  input  wire logic                   we,
  input  wire logic [`CCC_ADDR_W-1:0] addr,
  input  wire logic [`CCC_DATA_W-1:0] wdata,
  output logic      [`CCC_DATA_W-1:0] rdata
);

  logic [`CCC_DATA_W-1:0] mem_q [0:`CCC_MEM_WORDS-1];

  // contents are not reset; software must load the blocks it uses
  always_ff @(posedge clk)
  begin
    if (en && we)
    begin
      mem_q[addr] <= wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rdata <= 32'h0000_0000;
    end
    else if (en && !we)
    begin
      rdata <= mem_q[addr];
    end
  end

endmodule : ccc_shared_mem

// file: hw/ccc_command_ctrl.sv
//
// Overview of operation
// (R1) host writes commands to engine command register and observes completion
// (R2) each command names one serial channel controller to act on
// (R3) reset bit in the command resets the whole engine and all channels
// (R4) init command loads channel state from memory; done once channel ready
// (R5) host sets up all memory structures before the init command
// (R6) graceful stop keeps sending until the current frame ends
// (R7) stop transmit aborts once the channel transmit FIFOs are empty
// (R8) restart resumes transmission from the pointer saved at stop
// (R9) stop and start leave other channels untouched, no re-init
// (R10) accepted command codes depend on channel protocol; extra control codes
// (R11) shared memory is reachable by engine and by host
// (R12) each channel owns a parameter block in shared memory
// (R13) in HDLC mode a channel also uses a virtual FIFO region
// (R14) descriptors come from shared or external memory as host chooses
// (R15) per-channel mode, event, status registers decoded outside memory
// (R16) pending flag set on write, cleared on completion; host then waits; code sets it only for init, stops on a ready channel and reset
//
`timescale 1ns/1ps
`include "ccc_consts.svh"

module ccc_command_ctrl
  import ccc_pkg::*;
(
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   rst_b,
  // command register write
  input  wire logic                   cmd_wr,
  input  wire logic                   cmd_reset,
  input  wire logic [`CCC_OP_W-1:0]   cmd_opcode,
  input  wire logic [`CCC_CH_W-1:0]   cmd_channel,
  // command status
  output logic                        cmd_pending,
  output logic                        cmd_done,
  output logic                        cmd_error,
  output logic                        engine_reset,
  // host access to memory and channel registers
  input  wire logic                   host_req,
  input  wire logic                   host_we,
  input  wire logic                   host_space,
  input  wire logic [`CCC_ADDR_W-1:0] host_addr,
  input  wire logic [`CCC_DATA_W-1:0] host_wdata,
  output logic                        host_ack,
  output logic      [`CCC_DATA_W-1:0] host_rdata,
  // serial channel controllers
  input  wire ccc_chvec_t             tx_frame_active,
  input  wire ccc_chvec_t             tx_fifo_empty,
  input  wire ccc_ptrs_t              tx_cur_ptr,
  output ccc_chvec_t                  tx_enable,
  output ccc_chvec_t                  rx_enable,
  output ccc_chvec_t                  chan_ready,
  output ccc_chvec_t                  bd_from_ext,
  output ccc_chvec_t                  vfifo_enable,
  output ccc_ptrs_t                   tx_bd_ptr,
  output ccc_ptrs_t                   rx_bd_ptr
);

  // ----------------------------------------------------------------------
  // state and memory port
  // ----------------------------------------------------------------------
  ccc_state_s             s_reg;
  ccc_state_s             s_next;
  logic                   fetching;
  logic                   host_take;
  logic                   cmd_take;
  logic                   mem_en;
  logic                   mem_we;
  logic [`CCC_ADDR_W-1:0] mem_addr;
  logic [`CCC_DATA_W-1:0] mem_rdata;
  logic [`CCC_ADDR_W-1:0] pram_addr;

  function automatic logic op_legal(input logic [`CCC_OP_W-1:0] op,
                                    input logic [1:0] proto);
    logic ok;
    ok = 1'b0;
    case (op)
      `CCC_OP_INIT, `CCC_OP_STOP_TX, `CCC_OP_RESTART_TX,
      `CCC_OP_STOP_RX, `CCC_OP_RESTART_RX: ok = 1'b1;
      // no frames in uart mode, so a frame-end stop means nothing there
      `CCC_OP_GSTOP_TX: ok = (proto != `CCC_PROTO_UART);
      `CCC_OP_HUNT_RX:  ok = (proto == `CCC_PROTO_HDLC);
      default:          ok = 1'b0;
    endcase
    return ok;
  endfunction : op_legal

  assign fetching  = (s_reg.st == ST_FETCH0) || (s_reg.st == ST_FETCH1);
  assign cmd_take  = cmd_wr && !cmd_reset && (s_reg.st == ST_IDLE);
  // engine fetches own the memory port; host waits up to two cycles    
  assign host_take = host_req && !s_reg.h_p1 && !s_reg.ack && !fetching;
  assign pram_addr = `CCC_PRAM_BASE
                     + (`CCC_ADDR_W'(s_reg.ch) << `CCC_PRAM_SHIFT); // [R12]

  // [R11] one port shared by engine fetches and host accesses
  always_comb
  begin
    mem_en   = 1'b0;
    mem_we   = 1'b0;
    mem_addr = host_addr;
    if (s_reg.st == ST_FETCH0)
    begin
      mem_en   = 1'b1;
      mem_addr = pram_addr;
    end
    else if (s_reg.st == ST_FETCH1)
    begin
      mem_en   = 1'b1;
      mem_addr = pram_addr + 10'h001;
    end
    else if (host_take && !host_space)
    begin
      mem_en = 1'b1;
      mem_we = host_we;
    end
  end

  ccc_shared_mem u_mem
  (
    .clk   (clk),
    .rst_b (rst_b),
    .en    (mem_en),
    .we    (mem_we),
    .addr  (mem_addr),
    .wdata (host_wdata),
    .rdata (mem_rdata)
  );

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb
  begin
    logic [`CCC_NUM_CH-1:0][`CCC_EV_W-1:0] ev_set;
    logic [`CCC_NUM_CH-1:0][`CCC_EV_W-1:0] ev_clr;
    logic [`CCC_CH_W-1:0]                  hch;
    logic                                  clr_all;
    ev_set  = '0;
    ev_clr  = '0;
    hch     = host_addr[4:2];
    clr_all = 1'b0;
    s_next  = s_reg;
    s_next.done = 1'b0;
    s_next.err  = 1'b0;
    s_next.ack  = 1'b0;
    s_next.h_p1 = 1'b0;

    // host side: two-cycle answer for memory and registers alike
    if (s_reg.h_p1)
    begin
      s_next.ack   = 1'b1;
      s_next.rdata = s_reg.h_space ? s_reg.hold : mem_rdata;
    end
    if (host_take)
    begin
      s_next.h_p1    = 1'b1;
      s_next.h_space = host_space;
      s_next.hold    = 32'h0000_0000;
      if (host_space)
      begin
        // [R15] channel registers live outside the memory space
        if (host_addr[1:0] == `CCC_REG_MODE)
        begin
          s_next.hold[1:0] = s_reg.proto[hch];
          if (host_we)
            s_next.proto[hch] = host_wdata[1:0];
        end
        else if (host_addr[1:0] == `CCC_REG_EVENT)
        begin
          s_next.hold[`CCC_EV_W-1:0] = s_reg.events[hch];
          if (host_we)
            ev_clr[hch] = host_wdata[`CCC_EV_W-1:0];
        end
        else if (host_addr[1:0] == `CCC_REG_STATUS)
        begin
          s_next.hold[4:0] = {s_reg.vfifo_en[hch], s_reg.bd_ext[hch],
                              s_reg.ready[hch], s_reg.rx_en[hch],
                              s_reg.tx_en[hch]};
        end
      end
    end

    // command engine
    if (cmd_wr && cmd_reset)
    begin
      s_next.st      = ST_RESET; // [R3]
      s_next.pending = 1'b1;
      s_next.eng_rst = 1'b1;
      s_next.rst_cnt = `CCC_RESET_CYCLES;
      clr_all        = 1'b1;
    end
    else
    begin
      case (s_reg.st)
        ST_IDLE:
        begin
          if (cmd_take)
          begin
            s_next.ch = cmd_channel; // [R2]
            s_next.op = cmd_opcode;
            if (!op_legal(cmd_opcode, s_reg.proto[cmd_channel])) // [R10]
            begin
              s_next.err  = 1'b1;
              s_next.done = 1'b1;
            end
            else
            begin
              case (cmd_opcode)
                `CCC_OP_INIT:
                begin
                  s_next.st      = ST_FETCH0;
                  s_next.pending = 1'b1; // [R16]
                end
                `CCC_OP_GSTOP_TX, `CCC_OP_STOP_TX:
                begin
                  if (s_reg.ready[cmd_channel])
                  begin
                    s_next.st      = (cmd_opcode == `CCC_OP_STOP_TX)
                                     ? ST_STOP : ST_GSTOP;
                    s_next.pending = 1'b1;
                  end
                  else
                    s_next.done = 1'b1;
                end
                `CCC_OP_RESTART_TX:
                begin
                  // pointer untouched, so the channel picks up where it left
                  s_next.tx_en[cmd_channel] = s_reg.ready[cmd_channel]; // [R8]
                  s_next.done               = 1'b1;
                end
                `CCC_OP_STOP_RX:
                begin
                  s_next.rx_en[cmd_channel] = 1'b0;
                  s_next.done               = 1'b1;
                end
                `CCC_OP_RESTART_RX:
                begin
                  s_next.rx_en[cmd_channel] = s_reg.ready[cmd_channel];
                  s_next.done               = 1'b1;
                end
                default:
                begin
                  ev_set[cmd_channel][`CCC_EV_HUNT] = 1'b1;
                  s_next.done                       = 1'b1;
                end
              endcase
            end
          end
        end
        ST_FETCH0:
          s_next.st = ST_FETCH1;
        ST_FETCH1:
        begin
          s_next.st = ST_FETCH2;
          s_next.bd_ext[s_reg.ch] = mem_rdata[`CCC_PW0_BD_EXT]; // [R14]
          s_next.tx_ptr[s_reg.ch] =
            mem_rdata[`CCC_PW0_TXPTR_LSB +: `CCC_PTR_W]; // [R4]
        end
        ST_FETCH2:
        begin
          s_next.rx_ptr[s_reg.ch] =
            mem_rdata[`CCC_PW1_RXPTR_LSB +: `CCC_PTR_W]; // [R4]
          s_next.vfifo_en[s_reg.ch] =
            (s_reg.proto[s_reg.ch] == `CCC_PROTO_HDLC); // [R13]
          s_next.ready[s_reg.ch]    = 1'b1;
          s_next.tx_en[s_reg.ch]    = 1'b1;
          s_next.rx_en[s_reg.ch]    = 1'b1;
          ev_set[s_reg.ch][`CCC_EV_INIT_DONE] = 1'b1;
          s_next.st      = ST_IDLE;
          s_next.pending = 1'b0; // [R1]
          s_next.done    = 1'b1;
        end
        ST_GSTOP, ST_STOP:
        begin
          // only the addressed channel is touched here [R9]
          if ((s_reg.st == ST_GSTOP && !tx_frame_active[s_reg.ch]) || // [R6]
              (s_reg.st == ST_STOP && tx_fifo_empty[s_reg.ch])) // [R7]
          begin
            s_next.tx_en[s_reg.ch]  = 1'b0;
            s_next.tx_ptr[s_reg.ch] = tx_cur_ptr[s_reg.ch]; // [R8]
            ev_set[s_reg.ch][`CCC_EV_TX_STOPPED] = 1'b1;
            s_next.st      = ST_IDLE;
            s_next.pending = 1'b0;
            s_next.done    = 1'b1;
          end
        end
        default:
        begin
          clr_all = 1'b1;
          if (s_reg.rst_cnt == 3'h1)
          begin
            s_next.st      = ST_IDLE;
            s_next.eng_rst = 1'b0;
            s_next.pending = 1'b0;
            s_next.done    = 1'b1;
          end
          else
            s_next.rst_cnt = s_reg.rst_cnt - 3'h1;
        end
      endcase
    end

    // an event in the cycle of its clear is kept
    s_next.events = (s_reg.events & ~ev_clr) | ev_set;
    if (clr_all)
    begin
      s_next.tx_en    = '0; // [R3]
      s_next.rx_en    = '0;
      s_next.ready    = '0;
      s_next.bd_ext   = '0;
      s_next.vfifo_en = '0;
      s_next.tx_ptr   = '0;
      s_next.rx_ptr   = '0;
      s_next.proto    = '0;
      s_next.events   = '0;
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign cmd_pending  = s_reg.pending;
  assign cmd_done     = s_reg.done;
  assign cmd_error    = s_reg.err;
  assign engine_reset = s_reg.eng_rst;
  assign host_ack     = s_reg.ack;
  assign host_rdata   = s_reg.rdata;
  assign tx_enable    = s_reg.tx_en;
  assign rx_enable    = s_reg.rx_en;
  assign chan_ready   = s_reg.ready;
  assign bd_from_ext  = s_reg.bd_ext;
  assign vfifo_enable = s_reg.vfifo_en;
  assign tx_bd_ptr    = s_reg.tx_ptr;
  assign rx_bd_ptr    = s_reg.rx_ptr;

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence init_taken;
    cmd_take && cmd_opcode == `CCC_OP_INIT
    && op_legal(cmd_opcode, s_reg.proto[cmd_channel]);
  endsequence
  sequence init_fetch;
    cmd_pending && !cmd_done [*3];
  endsequence

  a_init_completes: assert property ( // [R4]
    init_taken |=> init_fetch ##1 (cmd_done && !cmd_pending
                                  && chan_ready[s_reg.ch]))
    else $error("init did not complete with channel ready");

  a_pending_rises: assert property ( // [R16]
    cmd_take && cmd_opcode == `CCC_OP_INIT |=> cmd_pending)
    else $error("pending flag not set on command");

  a_done_clears: assert property ( // [R1]
    cmd_done |-> !cmd_pending)
    else $error("done seen while still pending");

  a_reset_engine: assert property ( // [R3]
    cmd_wr && cmd_reset |=> engine_reset [*4] ##1
      (!engine_reset && cmd_done && tx_enable == '0 && chan_ready == '0))
    else $error("engine reset sequence wrong");

  a_gstop_frame: assert property ( // [R6]
    s_reg.st == ST_GSTOP && tx_frame_active[s_reg.ch]
      |=> tx_enable[s_reg.ch] && cmd_pending)
    else $error("graceful stop cut a frame");

  a_stop_drain: assert property ( // [R7]
    s_reg.st == ST_STOP && tx_fifo_empty[s_reg.ch]
      |=> !tx_enable[s_reg.ch] && cmd_done)
    else $error("stop did not end once fifo empty");

  a_restart_ptr: assert property ( // [R8]
    cmd_take && cmd_opcode == `CCC_OP_RESTART_TX
    && chan_ready[cmd_channel]
      |=> tx_enable[$past(cmd_channel)] && $stable(tx_bd_ptr) && cmd_done)
    else $error("restart moved pointer or left tx off");

  a_other_chans: assert property ( // [R9]
    (s_reg.st == ST_GSTOP || s_reg.st == ST_STOP) && !(cmd_wr && cmd_reset)
      |=> ((tx_enable ^ $past(tx_enable))
           & ~(ccc_chvec_t'(1) << $past(s_reg.ch))) == '0)
    else $error("stop disturbed another channel");

  a_reject_code: assert property ( // [R10]
    cmd_take && !op_legal(cmd_opcode, s_reg.proto[cmd_channel])
      |=> cmd_error && cmd_done && !cmd_pending)
    else $error("illegal code not refused");

  a_vfifo_hdlc: assert property ( // [R13]
    s_reg.st == ST_FETCH2 |=> vfifo_enable[$past(s_reg.ch)]
      == (s_reg.proto[$past(s_reg.ch)] == `CCC_PROTO_HDLC))
    else $error("virtual fifo not tied to hdlc mode");

  a_host_answer: assert property ( // [R11]
    host_take |-> !host_ack ##1 !host_ack ##1 host_ack)
    else $error("host access not answered in two cycles");

endmodule : ccc_command_ctrl

// file: testbench/ccc_host_model.sv
`timescale 1ns/1ps
`include "ccc_consts.svh"

module ccc_host_model
(
  // clock
  input  wire logic                   clk,
  // command register
  output logic                        cmd_wr,
  output logic                        cmd_reset,
  output logic      [`CCC_OP_W-1:0]   cmd_opcode,
  output logic      [`CCC_CH_W-1:0]   cmd_channel,
  input  wire logic                   cmd_pending,
  input  wire logic                   cmd_done,
  input  wire logic                   cmd_error,
  // memory and channel register access
  output logic                        host_req,
  output logic                        host_we,
  output logic                        host_space,
  output logic      [`CCC_ADDR_W-1:0] host_addr,
  output logic      [`CCC_DATA_W-1:0] host_wdata,
  input  wire logic                   host_ack
);
  initial
  begin
    cmd_wr      = 1'b0;
    cmd_reset   = 1'b0;
    cmd_opcode  = 4'hF;
    cmd_channel = 3'h7;
    host_req    = 1'b0;
    host_we     = 1'b0;
    host_space  = 1'b0;
    host_addr   = 10'h3FF;
    host_wdata  = 32'hFFFF_FFFF;
  end

  // one command write; n is cycles from the write to the done pulse
  task automatic issue(input logic rb, input logic [3:0] op,
                       input logic [2:0] ch, output int n,
                       output logic err);
    n = 0;
    err = 1'bx;
    while (cmd_pending !== 1'b0 && n < 200)
      @(negedge clk);
    @(negedge clk);
    cmd_wr      = 1'b1;
    cmd_reset   = rb;
    cmd_opcode  = op;
    cmd_channel = ch;
    while (n < 200)
    begin
      @(negedge clk);
      n++;
      if (n == 1)
      begin
        // strobes drop to 0; opcode and channel go to the inverse so stale values never match
        cmd_wr      = 1'b0;
        cmd_reset   = 1'b0;
        cmd_opcode  = ~op;
        cmd_channel = ~ch;
      end
      if (cmd_done === 1'b1)
      begin
        err = cmd_error;
        break;
      end
    end
  endtask : issue

  // request held until the acknowledge is seen
  task automatic access(input logic we, input logic sp,
                        input logic [9:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(negedge clk);
    host_req   = 1'b1;
    host_we    = we;
    host_space = sp;
    host_addr  = a;
    host_wdata = d;
    while (host_ack !== 1'b1 && n < 50)
    begin
      @(negedge clk);
      n++;
    end
    host_req   = 1'b0;
    host_addr  = ~a;
    host_wdata = ~d;
  endtask : access
endmodule : ccc_host_model

// file: testbench/tb_channel_command_control.sv
`timescale 1ns/1ps
`include "ccc_consts.svh"

module tb_channel_command_control
  import ccc_pkg::*;
;
  logic                   clk, rst_b, cmd_wr, cmd_reset, cmd_pending;
  logic                   cmd_done, cmd_error, engine_reset, host_req;
  logic                   host_we, host_space, host_ack, err;
  logic [`CCC_OP_W-1:0]   cmd_opcode;
  logic [`CCC_CH_W-1:0]   cmd_channel;
  logic [`CCC_ADDR_W-1:0] host_addr;
  logic [`CCC_DATA_W-1:0] host_wdata, host_rdata, rdv;
  ccc_chvec_t             tx_frame_active, tx_fifo_empty, tx_enable;
  ccc_chvec_t             rx_enable, chan_ready, bd_from_ext, vfifo_enable;
  ccc_ptrs_t              tx_cur_ptr, tx_bd_ptr, rx_bd_ptr;
  int                     n_fail, checked, cyc, lat;

  ccc_command_ctrl ccc_command_ctrl_inst
  (
    .clk, .rst_b, .cmd_wr, .cmd_reset, .cmd_opcode, .cmd_channel,
    .cmd_pending, .cmd_done, .cmd_error, .engine_reset, .host_req,
    .host_we, .host_space, .host_addr, .host_wdata, .host_ack,
    .host_rdata, .tx_frame_active, .tx_fifo_empty, .tx_cur_ptr,
    .tx_enable, .rx_enable, .chan_ready, .bd_from_ext, .vfifo_enable,
    .tx_bd_ptr, .rx_bd_ptr
  );

  ccc_host_model ccc_host_model_inst
  (
    .clk, .cmd_wr, .cmd_reset, .cmd_opcode, .cmd_channel, .cmd_pending,
    .cmd_done, .cmd_error, .host_req, .host_we, .host_space, .host_addr,
    .host_wdata, .host_ack
  );

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  task automatic chk(input string what, input logic [63:0] seen,
                     input logic [63:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("BAD %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : chk

  task automatic cmd(input logic rb, input logic [3:0] op,
                     input logic [2:0] ch);
    ccc_host_model_inst.issue(rb, op, ch, lat, err);
  endtask : cmd

  task automatic wr(input logic sp, input logic [9:0] a,
                    input logic [31:0] d);
    ccc_host_model_inst.access(1'b1, sp, a, d);
  endtask : wr

  task automatic rd(input logic sp, input logic [9:0] a);
    ccc_host_model_inst.access(1'b0, sp, a, 32'h0);
    rdv = host_rdata;
  endtask : rd

  task automatic complete_run;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : complete_run

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  // memory set up fully before any init command
  task automatic t_setup;
    chk("ready0", chan_ready, 8'h00);
    wr(1'b0, 10'h080, 32'h0000_4A01);
    wr(1'b0, 10'h081, 32'h0000_0033);
    wr(1'b0, 10'h140, 32'h0000_1700);
    wr(1'b0, 10'h141, 32'h0000_0066);
    wr(1'b1, 10'h008, 32'h0000_0001);
    wr(1'b1, 10'h014, 32'h0000_0000);
    rd(1'b0, 10'h080);
    chk("mem", rdv, 32'h0000_4A01);
    rd(1'b1, 10'h008);
    chk("mode", rdv, 32'h0000_0001);
    rd(1'b1, 10'h00B);
    chk("unmapped", rdv, 32'h0000_0000);
    $display("end t_setup");
  endtask : t_setup

  task automatic t_init;
    cmd(1'b0, `CCC_OP_INIT, 3'd2);
    chk("lat", lat, 4);
    chk("ready", chan_ready, 8'h04);
    chk("txrx", {tx_enable, rx_enable}, 16'h0404);
    chk("ptrs", {tx_bd_ptr[2], rx_bd_ptr[2]}, 16'h4A33);
    chk("ext", bd_from_ext, 8'h04);
    chk("vfifo", vfifo_enable, 8'h04);
    cmd(1'b0, `CCC_OP_INIT, 3'd5);
    chk("ready", chan_ready, 8'h24);
    chk("ptr5", {tx_bd_ptr[5], rx_bd_ptr[5]}, 16'h1766);
    chk("ext5", {bd_from_ext, vfifo_enable}, 16'h0404);
    chk("ptr2", tx_bd_ptr[2], 8'h4A);
    rd(1'b1, 10'h009);
    chk("event", rdv, 32'h0000_0001);
    rd(1'b1, 10'h00A);
    chk("status", rdv, 32'h0000_001F);
    $display("end t_init");
  endtask : t_init

  // stop ignores the frame, graceful stop waits for it
  task automatic t_stop;
    tx_cur_ptr[2] = 8'h51;
    tx_fifo_empty[2] = 1'b0;
    tx_frame_active[2] = 1'b1;
    fork
      cmd(1'b0, `CCC_OP_STOP_TX, 3'd2);
      begin
        repeat (3) @(negedge clk);
        tx_fifo_empty[2] = 1'b1;
      end
    join
    chk("lat", lat, 3);
    chk("tx", tx_enable, 8'h20);
    chk("ptr", tx_bd_ptr[2], 8'h51);
    tx_cur_ptr[2] = 8'h99;
    cmd(1'b0, `CCC_OP_RESTART_TX, 3'd2);
    chk("lat", lat, 1);
    chk("tx", tx_enable, 8'h24);
    chk("ptr", tx_bd_ptr[2], 8'h51);
    fork
      cmd(1'b0, `CCC_OP_GSTOP_TX, 3'd2);
      begin
        repeat (5) @(negedge clk);
        tx_frame_active[2] = 1'b0;
      end
    join
    chk("lat", lat, 5);
    chk("tx", {tx_enable, chan_ready}, 16'h2024);
    $display("end t_stop");
  endtask : t_stop

  task automatic t_codes;
    cmd(1'b0, `CCC_OP_GSTOP_TX, 3'd5);
    chk("err", {err, lat[3:0], tx_enable}, 13'h1120);
    cmd(1'b0, `CCC_OP_HUNT_RX, 3'd5);
    chk("err", err, 1'b1);
    cmd(1'b0, `CCC_OP_HUNT_RX, 3'd2);
    chk("err", err, 1'b0);
    for (int op = 7; op < 16; op++)
    begin
      cmd(1'b0, op[3:0], 3'd2);
      chk("err", err, 1'b1);
    end
    cmd(1'b0, `CCC_OP_STOP_RX, 3'd5);
    chk("rx", {err, rx_enable}, 9'h004);
    cmd(1'b0, `CCC_OP_RESTART_RX, 3'd5);
    chk("rx", {err, rx_enable}, 9'h024);
    rd(1'b1, 10'h009);
    chk("ev2", rdv, 32'h0000_0007);
    wr(1'b1, 10'h009, 32'h0000_0003);
    rd(1'b1, 10'h009);
    chk("evclr", rdv, 32'h0000_0004);
    $display("end t_codes");
  endtask : t_codes

  task automatic t_ereset;
    fork
      cmd(1'b1, `CCC_OP_INIT, 3'd0);
      begin
        repeat (3) @(negedge clk);
        chk("erst", {engine_reset, cmd_pending}, 2'b11);
      end
    join
    chk("lat", lat, 5);
    chk("chan", {chan_ready, tx_enable, rx_enable}, 24'h0);
    chk("ext", {bd_from_ext, vfifo_enable}, 16'h0);
    rd(1'b1, 10'h008);
    chk("mode", rdv, 32'h0);
    rd(1'b0, 10'h140);
    chk("mem", rdv, 32'h0000_1700);
    $display("end t_ereset");
  endtask : t_ereset

  // ----------------------------------------------------------------------
  // clock, timeout, sequence
  // ----------------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // the whole sequence takes well under a thousand cycles
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      n_fail++;
      complete_run();
    end
  end

  initial
  begin
    rst_b = 1'b0;
    tx_frame_active = 8'h00;
    tx_fifo_empty = 8'hFF;
    tx_cur_ptr = '0;
    repeat (2) @(negedge clk);
    rst_b = 1'b1;
    t_setup();
    t_init();
    t_stop();
    t_codes();
    t_ereset();
    complete_run();
  end
endmodule : tb_channel_command_control
